// ---- src/rst_vec_pkg.sv ----
// Shared constants and types for the reset and vector control block.
package rst_vec_pkg;
  localparam int NUM_IRQ = 8;
  localparam logic [8:0] RESET_VECTOR = 9'h0_000;
  localparam logic [1:0] DELAY_SEL_DEFAULT = 2'h0;
  localparam logic [1:0] DELAY_SEL_LONG_A = 2'h0;
  localparam logic [1:0] DELAY_SEL_LONG_B = 2'h1;
  localparam logic [1:0] DELAY_SEL_MID = 2'h2;
  localparam logic [1:0] DELAY_SEL_SHORT = 2'h3;
  localparam logic [16:0] WDOG_CYC_LONG = 17'h1_0000;
  localparam logic [16:0] WDOG_CYC_MID = 17'h0_1000;
  localparam logic [16:0] WDOG_CYC_SHORT_NOBOD = 17'h0_0008;
  localparam logic [16:0] WDOG_CYC_SHORT_BOD = 17'h0_0020;
  localparam logic [4:0] CLK_CYC_STARTUP = 5'h12;
  localparam int PIN_MIN_NS = 500;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PIN_MIN_CYC = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] ADDR_CAUSE = 32'h0000_0000;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQ_EN = 32'h0000_0008;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_000C;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_0010;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_EXT = 1;
  localparam int CAUSE_BOD = 2;
  localparam int CAUSE_WDOG = 3;
  localparam int CTRL_GIE = 0;
  localparam int CTRL_WAKE = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    SEQ_HOLD = 2'b00,
    SEQ_WDOG = 2'b01,
    SEQ_CLK = 2'b10,
    SEQ_RUN = 2'b11
  } seq_state_t;
endpackage

// ---- src/level_sync.sv ----
// Two-flop synchroniser for a level arriving from another domain.
`timescale 1ns/1ps
`default_nettype none
module level_sync
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic asyncIn,
  input wire logic resetVal,
  output logic syncOut
);
  import rst_vec_pkg::*;
  logic meta_ff;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      meta_ff <= asyncIn ^ resetVal;
      syncOut <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ---- src/irq_priority.sv ----
// Fixed-priority selection of the lowest pending enabled interrupt vector.
`timescale 1ns/1ps
`default_nettype none
module irq_priority
(
  input wire logic [rst_vec_pkg::NUM_IRQ-1:0] pending,
  output logic anyHit,
  output logic [8:0] vector
);
  import rst_vec_pkg::*;
  always_comb
  begin
    anyHit = 1'b0;
    vector = RESET_VECTOR;
    // Scanning from the top lets the lowest index overwrite, so it wins.
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        anyHit = 1'b1;
        vector = RESET_VECTOR + 9'(i + 1);
      end
    end
  end
endmodule
`default_nettype wire

// ---- src/reset_and_vector_control.sv ----
// Reset merging, start-up delay, reset-cause flags and interrupt vectoring.
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module reset_and_vector_control
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic porActive,
  input wire logic brownoutDetector,
  input wire logic extResetn,
  input wire logic wdogExpire,
  input wire logic wdogEnable,
  input wire logic wdogOscTick,
  input wire logic powerDownWake,
  input wire logic [1:0] startupDelaySelect,
  input wire logic brownoutEnableFuse,
  input wire logic [rst_vec_pkg::NUM_IRQ-1:0] irqRequest,
  input wire logic irqAck,
  input wire logic haddrValid,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic coreResetn,
  output logic [8:0] fetchVector,
  output logic irqTake,
  output logic irqOut
);
  import rst_vec_pkg::*;

  logic porSync, bodSync, pinLowSync, wdogSync, wdogEnSync, tickSync, wakeSync;
  logic tickPrev_ff;
  logic [NUM_IRQ-1:0] reqSync;
  logic [5:0] pinLowCnt_ff;
  logic pinReset_ff;
  logic wdogPulse_ff;
  logic wdogArmPrev_ff;
  logic anyReset;
  seq_state_t state_ff;
  logic [16:0] wdogCnt_ff;
  logic [4:0] clkCnt_ff;
  logic [16:0] wdogTarget;
  logic [3:0] cause_ff;
  logic [1:0] ctrl_ff;
  logic [NUM_IRQ-1:0] irqEn_ff;
  logic [3:0] irqStat_ff;
  logic [3:0] irqMask_ff;
  logic [3:0] events;
  logic [NUM_IRQ-1:0] eligible;
  logic anyHit;
  logic [8:0] selVector;
  logic wrPend_ff, rdPend_ff;
  logic [31:0] addrLatch_ff;
  logic wrCause, wrCtrl, wrEn, wrStat, wrMask;

  // Pins and analog detectors are asynchronous; each passes two flops first.
  level_sync uPor (.mclk(mclk), .resetn(resetn), .asyncIn(porActive), .resetVal(1'b0),
    .syncOut(porSync));
  level_sync uBod (.mclk(mclk), .resetn(resetn), .asyncIn(brownoutDetector),
    .resetVal(1'b0), .syncOut(bodSync));
  level_sync uPin (.mclk(mclk), .resetn(resetn), .asyncIn(extResetn), .resetVal(1'b1),
    .syncOut(pinLowSync));
  level_sync uWdg (.mclk(mclk), .resetn(resetn), .asyncIn(wdogExpire), .resetVal(1'b0),
    .syncOut(wdogSync));
  level_sync uWdgEn (.mclk(mclk), .resetn(resetn), .asyncIn(wdogEnable), .resetVal(1'b0),
    .syncOut(wdogEnSync));
  level_sync uTick (.mclk(mclk), .resetn(resetn), .asyncIn(wdogOscTick), .resetVal(1'b0),
    .syncOut(tickSync));
  level_sync uWake (.mclk(mclk), .resetn(resetn), .asyncIn(powerDownWake),
    .resetVal(1'b0), .syncOut(wakeSync));

  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++)
    begin : gReq
      level_sync uReq (.mclk(mclk), .resetn(resetn), .asyncIn(irqRequest[g]),
        .resetVal(1'b0), .syncOut(reqSync[g]));
    end
  endgenerate

  // A pin held low past the minimum width counts as a pin reset; a system
  // without a running clock is covered by the asynchronous resetn path.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinLowCnt_ff <= '0;
      pinReset_ff <= 1'b0;
    end
    else if (pinLowSync)
    begin
      if (pinLowCnt_ff != 6'(PIN_MIN_CYC))
        pinLowCnt_ff <= pinLowCnt_ff + 6'h1;
      pinReset_ff <= (pinLowCnt_ff == 6'(PIN_MIN_CYC)) || pinReset_ff;
    end
    else
    begin
      pinLowCnt_ff <= '0;
      pinReset_ff <= 1'b0;
    end
  end

  // Only the rising edge of an enabled expiry counts, so a level held high
  // gives a single one-clock pulse and the delay starts right after it.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wdogArmPrev_ff <= 1'b0;
      wdogPulse_ff <= 1'b0;
    end
    else
    begin
      wdogArmPrev_ff <= wdogSync && wdogEnSync;
      wdogPulse_ff <= wdogSync && wdogEnSync && !wdogArmPrev_ff;
    end
  end

  assign anyReset = porSync || (bodSync && brownoutEnableFuse) || pinReset_ff
    || wdogPulse_ff;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      tickPrev_ff <= 1'b0;
    else
      tickPrev_ff <= tickSync;
  end

  always_comb
  begin
    case (startupDelaySelect)
      DELAY_SEL_LONG_A: wdogTarget = WDOG_CYC_LONG;
      DELAY_SEL_LONG_B: wdogTarget = WDOG_CYC_LONG;
      DELAY_SEL_MID: wdogTarget = WDOG_CYC_MID;
      default: wdogTarget = brownoutEnableFuse ? WDOG_CYC_SHORT_BOD : WDOG_CYC_SHORT_NOBOD;
    endcase
  end

  // Start-up sequencer: watchdog-oscillator part, then the clock-counted part.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= SEQ_HOLD;
      wdogCnt_ff <= '0;
      clkCnt_ff <= '0;
    end
    else if (anyReset)
    begin
      state_ff <= SEQ_HOLD;
      wdogCnt_ff <= '0;
      clkCnt_ff <= '0;
    end
    else
    begin
      case (state_ff)
        SEQ_HOLD:
          state_ff <= SEQ_WDOG;
        SEQ_WDOG:
          if (tickSync && !tickPrev_ff)
          begin
            if (wdogCnt_ff == wdogTarget - 17'h1)
              state_ff <= SEQ_CLK;
            wdogCnt_ff <= wdogCnt_ff + 17'h1;
          end
        SEQ_CLK:
          if (clkCnt_ff == CLK_CYC_STARTUP - 5'h1)
            state_ff <= SEQ_RUN;
          else
            clkCnt_ff <= clkCnt_ff + 5'h1;
        SEQ_RUN:
          if (wakeSync)
          begin
            state_ff <= SEQ_CLK;
            clkCnt_ff <= '0;
          end
        default:
          state_ff <= SEQ_HOLD;
      endcase
    end
  end

  // The core's reset also reloads its peripheral registers; the working
  // register file has no reset input and so keeps its contents.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      coreResetn <= 1'b0;
    else
      coreResetn <= (state_ff == SEQ_RUN) && !anyReset;
  end

  // Cause flags: set wins over a software clear in the same cycle.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cause_ff <= 4'h1;
    else
    begin
      if (porSync)
        cause_ff <= 4'h1;
      else
      begin
        cause_ff[CAUSE_EXT] <= pinReset_ff || (cause_ff[CAUSE_EXT]
          && !(wrCause && !hwdata[CAUSE_EXT]));
        cause_ff[CAUSE_BOD] <= (bodSync && brownoutEnableFuse) || (cause_ff[CAUSE_BOD]
          && !(wrCause && !hwdata[CAUSE_BOD]));
        cause_ff[CAUSE_WDOG] <= wdogPulse_ff || (cause_ff[CAUSE_WDOG]
          && !(wrCause && !hwdata[CAUSE_WDOG]));
        cause_ff[CAUSE_POR] <= cause_ff[CAUSE_POR] && !(wrCause && !hwdata[CAUSE_POR]);
      end
    end
  end

  // Interrupt selection and vectoring.
  assign eligible = reqSync & irqEn_ff & {NUM_IRQ{ctrl_ff[CTRL_GIE]}};

  irq_priority uPri (.pending(eligible), .anyHit(anyHit), .vector(selVector));

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetchVector <= RESET_VECTOR;
      irqTake <= 1'b0;
    end
    // Follows the next value of coreResetn, so no stale vector shows while held.
    else if (state_ff != SEQ_RUN || anyReset)
    begin
      fetchVector <= RESET_VECTOR;
      irqTake <= 1'b0;
    end
    else
    begin
      fetchVector <= anyHit ? selVector : fetchVector;
      irqTake <= anyHit && !irqTake;
    end
  end

  // Software registers; taking an interrupt clears the global enable.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_ff <= '0;
      irqEn_ff <= '0;
      irqMask_ff <= '0;
    end
    else
    begin
      if (wrCtrl)
        ctrl_ff <= hwdata[1:0];
      else if (irqTake || irqAck)
        ctrl_ff[CTRL_GIE] <= 1'b0;
      if (wrEn)
        irqEn_ff <= hwdata[NUM_IRQ-1:0];
      if (wrMask)
        irqMask_ff <= hwdata[3:0];
    end
  end

  assign events = {wdogPulse_ff, bodSync && brownoutEnableFuse, pinReset_ff, porSync};

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      irqStat_ff <= '0;
    else
      irqStat_ff <= events | (irqStat_ff & ~(wrStat ? hwdata[3:0] : 4'h0));
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      irqOut <= 1'b0;
    else
      irqOut <= |(irqStat_ff & irqMask_ff);
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      addrLatch_ff <= '0;
    end
    else if (hready)
    begin
      wrPend_ff <= hsel && htrans == HTRANS_NONSEQ && hwrite;
      rdPend_ff <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
      addrLatch_ff <= haddr;
    end
  end

  assign wrCause = wrPend_ff && addrLatch_ff == ADDR_CAUSE;
  assign wrCtrl = wrPend_ff && addrLatch_ff == ADDR_CTRL;
  assign wrEn = wrPend_ff && addrLatch_ff == ADDR_IRQ_EN;
  assign wrStat = wrPend_ff && addrLatch_ff == ADDR_IRQ_STAT;
  assign wrMask = wrPend_ff && addrLatch_ff == ADDR_IRQ_MASK;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      hrdata <= '0;
    else if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite)
    begin
      case (haddr)
        ADDR_CAUSE: hrdata <= {28'h000_0000, cause_ff};
        ADDR_CTRL: hrdata <= {30'h0000_0000, ctrl_ff};
        ADDR_IRQ_EN: hrdata <= {24'h00_0000, irqEn_ff};
        ADDR_IRQ_STAT: hrdata <= {28'h000_0000, irqStat_ff};
        ADDR_IRQ_MASK: hrdata <= {28'h000_0000, irqMask_ff};
        default: hrdata <= '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- verification/reset_and_vector_control_checker.sv ----
// Concurrent assertions watching the reset and vector control block.
`timescale 1ns/1ps
`default_nettype none
module reset_and_vector_control_checker
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic porActive,
  input wire logic brownoutDetector,
  input wire logic brownoutEnableFuse,
  input wire logic extResetn,
  input wire logic powerDownWake,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic coreResetn,
  input wire logic [8:0] fetchVector,
  input wire logic irqTake
);
  import rst_vec_pkg::*;
  logic [7:0] quietCnt;
  logic [7:0] pinLowCnt;
  logic anySrc;
  assign anySrc = porActive | !extResetn | (brownoutDetector & brownoutEnableFuse);
  // Cycles since the last level reset source; the release must never beat the delay.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      quietCnt <= 8'h0;
    else if (anySrc)
      quietCnt <= 8'h0;
    else if (quietCnt != 8'hFF)
      quietCnt <= quietCnt + 8'h1;
  end
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      pinLowCnt <= 8'h0;
    else if (extResetn)
      pinLowCnt <= 8'h0;
    else if (pinLowCnt != 8'hFF)
      pinLowCnt <= pinLowCnt + 8'h1;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence porLow;
    porActive [*4];
  endsequence
  sequence bodLow;
    (brownoutDetector && brownoutEnableFuse) [*4];
  endsequence
  bus_resp_a: assert property (hreadyout && !hresp)
    else $error("bus response not ready and okay");
  vec_zero_a: assert property (!coreResetn |-> fetchVector == RESET_VECTOR)
    else $error("vector not zero during reset");
  por_hold_a: assert property (porLow |=> !coreResetn)
    else $error("core running while supply low");
  bod_hold_a: assert property (bodLow |=> !coreResetn)
    else $error("core running during brown-out");
  pin_hold_a: assert property (pinLowCnt >= 8'h3C |-> !coreResetn)
    else $error("core running with reset pin held low");
  release_delay_a: assert property ($rose(coreResetn) |-> quietCnt >= 8'h1A)
    else $error("core released before start-up delay");
  take_range_a: assert property (irqTake |-> coreResetn && fetchVector inside {[1:8]})
    else $error("interrupt vector out of range");
  // Taking clears the global enable, so no further take follows for a while.
  take_pulse_a: assert property (irqTake |=> !irqTake [*4])
    else $error("interrupt taken twice in a row");
  wake_restart_a: assert property ($rose(powerDownWake) && coreResetn |-> ##[1:4] !coreResetn)
    else $error("wake did not restart core reset");
endmodule
bind reset_and_vector_control reset_and_vector_control_checker u_chk (.mclk, .resetn,
  .porActive, .brownoutDetector, .brownoutEnableFuse, .extResetn, .powerDownWake,
  .hreadyout, .hresp, .coreResetn, .fetchVector, .irqTake);
`default_nettype wire

// ---- verification/irq_source_model.sv ----
// Model of the peripherals that raise interrupt requests toward the block.
`timescale 1ns/1ps
`default_nettype none
module irq_source_model
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [rst_vec_pkg::NUM_IRQ-1:0] raise,
  input wire logic clearAll,
  input wire logic irqTake,
  input wire logic [8:0] fetchVector,
  output logic [rst_vec_pkg::NUM_IRQ-1:0] irqRequest
);
  import rst_vec_pkg::*;
  // A source drops its request once the core has been vectored to it.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      irqRequest <= '0;
    else if (clearAll)
      irqRequest <= '0;
    else if (irqTake)
      irqRequest <= (irqRequest | raise) & ~(8'h01 << (fetchVector - 9'h1));
    else
      irqRequest <= irqRequest | raise;
  end
endmodule
`default_nettype wire

// ---- verification/reset_and_vector_control_test.sv ----
// Self-checking testbench for the reset and vector control block.
`timescale 1ns/1ps
`default_nettype none
module reset_and_vector_control_test;
  import rst_vec_pkg::*;
  logic mclk, resetn, porActive, brownoutDetector, extResetn, wdogExpire, wdogEnable;
  logic powerDownWake, brownoutEnableFuse, clearAll, hwrite, hreadyout, hresp;
  logic coreResetn, irqTake, irqOut, rdPend;
  logic [7:0] irqRequest, raise, req, en;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, delaySel;
  logic [8:0] fetchVector;
  logic [2:0] tickDiv = 3'h0;
  logic [31:0] expRd[$];
  logic [31:0] expVec[$];
  int error_cnt, check_count, seed, n;
  reset_and_vector_control u_dut (.mclk, .resetn, .porActive, .brownoutDetector, .extResetn,
    .wdogExpire, .wdogEnable, .wdogOscTick(tickDiv[2]), .powerDownWake,
    .startupDelaySelect(delaySel), .brownoutEnableFuse, .irqRequest, .irqAck(1'b0),
    .haddrValid(1'b0), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .coreResetn, .fetchVector, .irqTake,
    .irqOut);
  irq_source_model u_src (.mclk, .resetn, .raise, .clearAll, .irqTake, .fetchVector,
    .irqRequest);
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // The watchdog oscillator runs eight times slower than the system clock.
  always @(posedge mclk) tickDiv <= tickDiv + 3'h1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic [31:0] addr, input logic wr, input logic [31:0] data);
    haddr <= addr;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= data;
    rdPend <= !wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rdPend <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
    expRd.push_back(exp);
    bus(addr, 1'b0, 32'h0);
  endtask
  task automatic waitCore(input logic v);
    n = 0;
    while (coreResetn !== v && n < 3000)
    begin
      @(posedge mclk);
      n++;
    end
    check({31'h0, coreResetn}, {31'h0, v});
  endtask
  function automatic logic [31:0] lowVec(input logic [7:0] m);
    lowVec = 32'h0;
    for (int i = 7; i >= 0; i--)
      if (m[i])
        lowVec = i + 1;
  endfunction
  // Read data and taken vectors are compared against the oldest note when they appear.
  always @(posedge mclk)
  begin
    if (rdPend && hreadyout === 1'b1)
      check(hrdata, expRd.pop_front());
    if (irqTake === 1'b1)
      check({23'h0, fetchVector}, expVec.pop_front());
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    results();
  end
  initial
  begin
    {resetn, brownoutDetector, wdogExpire, wdogEnable, powerDownWake} = 5'h0;
    {brownoutEnableFuse, clearAll, hwrite, rdPend, raise, htrans} = 14'h0;
    {porActive, extResetn, haddr, hwdata, seed} = {2'h3, 64'h0, 32'ha783};
    delaySel = DELAY_SEL_SHORT;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(ADDR_CAUSE, 32'h1);
    porActive <= 1'b0;
    waitCore(1'b1);
    bus(ADDR_CAUSE, 1'b1, 32'h0);
    rd(ADDR_CAUSE, 32'h0);
    rd(32'h20, 32'h0);
    for (int k = 0; k < 12; k++)
    begin
      req = 8'($random(seed)) | 8'h80;
      en = 8'($random(seed)) | 8'h80;
      bus(ADDR_IRQ_EN, 1'b1, {24'h0, en});
      raise <= req;
      @(posedge mclk);
      raise <= 8'h0;
      expVec.push_back(lowVec(req & en));
      bus(ADDR_CTRL, 1'b1, 32'h1);
      n = 0;
      while (irqTake !== 1'b1 && n < 50)
      begin
        @(posedge mclk);
        n++;
      end
      check({31'h0, irqTake}, 32'h1);
      clearAll <= 1'b1;
      @(posedge mclk);
      clearAll <= 1'b0;
    end
    bus(ADDR_IRQ_STAT, 1'b1, 32'hF);
    extResetn <= 1'b0;
    repeat (60) @(posedge mclk);
    waitCore(1'b0);
    extResetn <= 1'b1;
    waitCore(1'b1);
    rd(ADDR_CAUSE, 32'h2);
    rd(ADDR_IRQ_STAT, 32'h2);
    bus(ADDR_IRQ_MASK, 1'b1, 32'h2);
    repeat (3) @(posedge mclk);
    check({31'h0, irqOut}, 32'h1);
    bus(ADDR_IRQ_STAT, 1'b1, 32'h2);
    repeat (3) @(posedge mclk);
    check({31'h0, irqOut}, 32'h0);
    wdogExpire <= 1'b1;
    repeat (6) @(posedge mclk);
    wdogExpire <= 1'b0;
    check({31'h0, coreResetn}, 32'h1);
    @(posedge mclk);
    wdogEnable <= 1'b1;
    wdogExpire <= 1'b1;
    waitCore(1'b0);
    wdogExpire <= 1'b0;
    wdogEnable <= 1'b0;
    waitCore(1'b1);
    rd(ADDR_CAUSE, 32'hA);
    brownoutEnableFuse <= 1'b1;
    brownoutDetector <= 1'b1;
    waitCore(1'b0);
    brownoutDetector <= 1'b0;
    waitCore(1'b1);
    rd(ADDR_CAUSE, 32'hE);
    powerDownWake <= 1'b1;
    waitCore(1'b0);
    powerDownWake <= 1'b0;
    waitCore(1'b1);
    check(32'(n), 32'(CLK_CYC_STARTUP));
    porActive <= 1'b1;
    waitCore(1'b0);
    rd(ADDR_CAUSE, 32'h1);
    // The mid code needs far more clocks than the run allows, so the core must still be held.
    delaySel <= DELAY_SEL_MID;
    porActive <= 1'b0;
    repeat (2000) @(posedge mclk);
    check({31'h0, coreResetn}, 32'h0);
    // A power-on pulse mid-count must restart a full short delay: at least seven
    // tick periods of eight clocks plus the 18 counted clocks.
    delaySel <= DELAY_SEL_SHORT;
    porActive <= 1'b1;
    repeat (4) @(posedge mclk);
    porActive <= 1'b0;
    waitCore(1'b1);
    check({31'h0, n >= 32'h4A}, 32'h1);
    results();
  end
endmodule
`default_nettype wire
